/* rtcv_pkg.sv */
// constants shared by the calendar status, validation and interrupt block
package rtcv_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int LV_SAMPLE_US = 15_600;
  localparam int LV_SAMPLE_CYC = LV_SAMPLE_US * (CLK_HZ / 1_000_000);
  localparam int OSC_EDGES_PER_TICK = 1024;
  localparam int SUB_TICKS_PER_SEC = 32;
  localparam int SEC_PER_UPCOUNT = 60;
  // register byte offsets
  localparam logic [7:0] OFF_STATUS1 = 8'h00;
  localparam logic [7:0] OFF_STATUS2 = 8'h04;
  localparam logic [7:0] OFF_PIN1REG = 8'h08;
  localparam logic [7:0] OFF_PIN2REG = 8'h0C;
  localparam logic [7:0] OFF_YEAR = 8'h10;
  localparam logic [7:0] OFF_MONTH = 8'h14;
  localparam logic [7:0] OFF_DAY = 8'h18;
  localparam logic [7:0] OFF_WDAY = 8'h1C;
  localparam logic [7:0] OFF_HOUR = 8'h20;
  localparam logic [7:0] OFF_MIN = 8'h24;
  localparam logic [7:0] OFF_SEC = 8'h28;
  localparam logic [7:0] OFF_CORR = 8'h2C;
  localparam logic [7:0] OFF_FREE1 = 8'h30;
  localparam logic [7:0] OFF_FREE2 = 8'h34;
  localparam logic [7:0] OFF_FREE3 = 8'h38;
  localparam logic [7:0] OFF_UPCNT = 8'h3C;
  localparam logic [7:0] OFF_ALEXT1 = 8'h40;
  localparam logic [7:0] OFF_ALEXT2 = 8'h44;
  localparam logic [7:0] OFF_INIT = 8'h48;
  // status register 1 fields
  localparam int S1_POWER_ON = 0;
  localparam int S1_LOW_VOLT = 1;
  localparam int S1_H24 = 6;
  localparam logic [7:0] S1_INIT_KEEP = 8'h70;
  // status register 2 fields
  localparam int S2_P1_FREQ = 0;
  localparam int S2_P1_ALARM = 1;
  localparam int S2_P1_32K = 2;
  localparam int S2_P2_FREQ = 3;
  localparam int S2_P2_ALARM = 4;
  // alarm field enables: bit 7 of each byte; expansion enables above
  localparam int AL_EN = 7;
  localparam int EXT_YEAR_EN = 24;
  localparam int EXT_MON_EN = 25;
  localparam int EXT_DAY_EN = 26;
  localparam int HOUR_PM = 6;
  // reset values
  localparam logic [7:0] RST_STATUS1 = 8'h01;
  localparam logic [7:0] RST_STATUS2 = 8'h01;
  localparam logic [23:0] RST_PIN1REG = 24'h000080;
  localparam logic [7:0] RST_DATE = 8'h01;
endpackage

/* rtcv_core.sv */
// status flags, write validation, calendar and interrupt pins of the clock
// Summary of operation
// - power-on reset loads calendar 00-01-01, status 01h, pin-one reg 80h.
// - power-on sets the power-on flag, status one bit zero.
// - after power-on pin one outputs a 1 Hz frequency pulse train.
// - host initializes while power-on flag set; init clears it and frequency mode.
// - init resets calendar and clears status two, pin, correction, free, expansion.
// - init loads status one bits six to four from written data, rest zero.
// - init leaves the 24-bit elapsed counter counting untouched.
// - supply sampled once per second for 15.6 ms into low-voltage flag.
// - low sample sets flag, stops sampling; flag holds after recovery.
// - init or a read of the flag clears it and restarts sampling.
// - invalid year to 00, month and day to 01, weekday 7 to 0.
// - invalid hour or minute fields on time write become 00; seconds are stored as written.
// - invalid seconds fixed at next carry, which also advances minutes.
// - 12-hour mode keeps written pm flag; 24-hour mode derives it on read.
// - nonexistent day of month becomes first day of next month.
// - status two selects each pin's mode; pin one adds 32.768 kHz output.
// - alarm match drives pin low until the host clears its alarm enable.
// - alarm compares weekday, hour, minute and expansion year, month, day.
// - re-enabled alarm during match waits for the next minute increment.
// - frequency mode outputs the AND of all enabled frequencies.
// - pin register bits seven to three enable 1 to 16 Hz; low bits store.
`timescale 1ns/10ps
`default_nettype none
module rtcv_core #(
  parameter int LV_SAMPLE_CYCLES = rtcv_pkg::LV_SAMPLE_CYC,
  // oscillator rises per 32 Hz tick; a bench may shorten the second
  parameter int OSC_TICK_EDGES = rtcv_pkg::OSC_EDGES_PER_TICK
) (
  // clock and power-on reset
  input wire logic clk,
  input wire logic nrst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // oscillator and supply monitor pins
  input wire logic osc_clk,
  input wire logic vdd_low,
  // interrupt pins, open drain
  output logic interrupt_pin_one_o,
  output logic interrupt_pin_one_oe,
  output logic interrupt_pin_two_o,
  output logic interrupt_pin_two_oe
);
  logic osc_s1_r, osc_s2_r, osc_s3_r, vdd_s1_r, vdd_s2_r;
  logic [9:0] edge_cnt_r;
  logic [4:0] sub_r;
  logic tick32, sec_tick, osc_rise;
  logic [7:0] st1_r, st2_r, corr_r, free1_r, free2_r, free3_r;
  logic [23:0] pin1_r, pin2_r, upcnt_r;
  logic [26:0] ext1_r, ext2_r;
  logic [5:0] up_sec_r;
  logic [7:0] year_r, mon_r, day_r, hour_r, min_r, sec_r;
  logic [2:0] wday_r;
  logic lv_samp_r, min_step_r, hit1_r, hit2_r, al1_r, al2_r;
  logic [31:0] lv_cnt_r;
  logic [31:0] prdata_r;
  logic apb_wr, apb_rd, init_pulse, h24, lv_set, lv_clr, mapped;
  logic hit1, hit2, lvl1, lvl2, pm_rd;
  logic [7:0] cy, cm, cd, ny, nm, nd, fx;

  function automatic logic nib_ok(input logic [7:0] v);
    return (v[7:4] <= 4'h9) && (v[3:0] <= 4'h9);
  endfunction
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    return (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
  endfunction
  function automatic logic [7:0] dim(input logic [7:0] m, input logic [7:0] y);
    logic leap;
    leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6) :
      (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    case (m)
      8'h02: dim = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: dim = 8'h30;
      default: dim = 8'h31;
    endcase
  endfunction
  function automatic logic hit(input logic [23:0] p, input logic [26:0] e,
    input logic [2:0] wd, input logic [7:0] hr, input logic pm,
    input logic is24, input logic [7:0] mi, input logic [7:0] yr,
    input logic [7:0] mo, input logic [7:0] dy);
    logic w, h, m, d;
    w = !p[rtcv_pkg::AL_EN] || p[2:0] == wd;
    h = !p[8 + rtcv_pkg::AL_EN] || (p[13:8] == hr[5:0] &&
      (is24 || p[8 + rtcv_pkg::HOUR_PM] == pm));
    m = !p[16 + rtcv_pkg::AL_EN] || p[22:16] == mi[6:0];
    d = (!e[rtcv_pkg::EXT_YEAR_EN] || e[7:0] == yr) &&
      (!e[rtcv_pkg::EXT_MON_EN] || e[15:8] == mo) &&
      (!e[rtcv_pkg::EXT_DAY_EN] || e[23:16] == dy);
    return w && h && m && d;
  endfunction

  // apb: zero wait states, unmapped offsets answer with an error
  assign pready = 1'b1;
  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && penable && !pwrite;
  assign init_pulse = apb_wr && paddr == rtcv_pkg::OFF_INIT;
  assign h24 = st1_r[rtcv_pkg::S1_H24];
  assign pm_rd = h24 ? (hour_r >= 8'h12) : hour_r[rtcv_pkg::HOUR_PM];
  always_comb
  begin
    case (paddr)
      rtcv_pkg::OFF_STATUS1, rtcv_pkg::OFF_STATUS2, rtcv_pkg::OFF_PIN1REG,
      rtcv_pkg::OFF_PIN2REG, rtcv_pkg::OFF_YEAR, rtcv_pkg::OFF_MONTH,
      rtcv_pkg::OFF_DAY, rtcv_pkg::OFF_WDAY, rtcv_pkg::OFF_HOUR,
      rtcv_pkg::OFF_MIN, rtcv_pkg::OFF_SEC, rtcv_pkg::OFF_CORR,
      rtcv_pkg::OFF_FREE1, rtcv_pkg::OFF_FREE2, rtcv_pkg::OFF_FREE3,
      rtcv_pkg::OFF_UPCNT, rtcv_pkg::OFF_ALEXT1, rtcv_pkg::OFF_ALEXT2,
      rtcv_pkg::OFF_INIT: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !mapped;

  // read data captured in the setup phase so it comes from flip-flops
  always_ff @(posedge clk)
  begin
    if (!nrst)
      prdata_r <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
    begin
      case (paddr)
        rtcv_pkg::OFF_STATUS1: prdata_r <= {24'h0, st1_r};
        rtcv_pkg::OFF_STATUS2: prdata_r <= {24'h0, st2_r};
        rtcv_pkg::OFF_PIN1REG: prdata_r <= {8'h0, pin1_r};
        rtcv_pkg::OFF_PIN2REG: prdata_r <= {8'h0, pin2_r};
        rtcv_pkg::OFF_YEAR: prdata_r <= {24'h0, year_r};
        rtcv_pkg::OFF_MONTH: prdata_r <= {24'h0, mon_r};
        rtcv_pkg::OFF_DAY: prdata_r <= {24'h0, day_r};
        rtcv_pkg::OFF_WDAY: prdata_r <= {29'h0, wday_r};
        rtcv_pkg::OFF_HOUR: prdata_r <= {25'h0, pm_rd, hour_r[5:0]};
        rtcv_pkg::OFF_MIN: prdata_r <= {24'h0, min_r};
        rtcv_pkg::OFF_SEC: prdata_r <= {24'h0, sec_r};
        rtcv_pkg::OFF_CORR: prdata_r <= {24'h0, corr_r};
        rtcv_pkg::OFF_FREE1: prdata_r <= {24'h0, free1_r};
        rtcv_pkg::OFF_FREE2: prdata_r <= {24'h0, free2_r};
        rtcv_pkg::OFF_FREE3: prdata_r <= {24'h0, free3_r};
        rtcv_pkg::OFF_UPCNT: prdata_r <= {8'h0, upcnt_r};
        rtcv_pkg::OFF_ALEXT1: prdata_r <= {5'h0, ext1_r};
        rtcv_pkg::OFF_ALEXT2: prdata_r <= {5'h0, ext2_r};
        default: prdata_r <= 32'h0000_0000;
      endcase
    end
  end
  assign prdata = prdata_r;

  // oscillator pin synchronised, edges divided to 32 Hz and 1 Hz enables
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      osc_s1_r <= 1'b0;
      osc_s2_r <= 1'b0;
      osc_s3_r <= 1'b0;
      vdd_s1_r <= 1'b0;
      vdd_s2_r <= 1'b0;
    end
    else
    begin
      osc_s1_r <= osc_clk;
      osc_s2_r <= osc_s1_r;
      osc_s3_r <= osc_s2_r;
      vdd_s1_r <= vdd_low;
      vdd_s2_r <= vdd_s1_r;
    end
  end
  assign osc_rise = osc_s2_r && !osc_s3_r;
  assign tick32 = osc_rise &&
    edge_cnt_r == 10'(OSC_TICK_EDGES - 1);
  assign sec_tick = tick32 &&
    sub_r == 5'(rtcv_pkg::SUB_TICKS_PER_SEC - 1);
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      edge_cnt_r <= 10'h000;
      sub_r <= 5'h00;
    end
    else if (osc_rise)
    begin
      edge_cnt_r <= tick32 ? 10'h000 : edge_cnt_r + 10'h001;
      if (tick32)
        sub_r <= sub_r + 5'h01;
    end
  end

  // elapsed-minute counter: cleared only by power-on
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      up_sec_r <= 6'h00;
      upcnt_r <= 24'h000000;
    end
    else if (sec_tick)
    begin
      if (up_sec_r == 6'(rtcv_pkg::SEC_PER_UPCOUNT - 1))
      begin
        up_sec_r <= 6'h00;
        upcnt_r <= upcnt_r + 24'h000001;
      end
      else
        up_sec_r <= up_sec_r + 6'h01;
    end
  end

  // supply sampling window, one per second
  assign lv_set = lv_samp_r && vdd_s2_r;
  assign lv_clr = init_pulse || (apb_rd && paddr == rtcv_pkg::OFF_STATUS1);
  always_ff @(posedge clk)
  begin
    if (!nrst || lv_set)
    begin
      lv_samp_r <= 1'b0;
      lv_cnt_r <= 32'h0;
    end
    else if (lv_samp_r)
    begin
      lv_cnt_r <= lv_cnt_r + 32'h1;
      if (lv_cnt_r == 32'(LV_SAMPLE_CYCLES - 1))
        lv_samp_r <= 1'b0;
    end
    else if (sec_tick && (!st1_r[rtcv_pkg::S1_LOW_VOLT] || lv_clr))
    begin
      lv_samp_r <= 1'b1;
      lv_cnt_r <= 32'h0;
    end
  end

  // status, pin and storage registers
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      st1_r <= rtcv_pkg::RST_STATUS1;
      st2_r <= rtcv_pkg::RST_STATUS2;
      pin1_r <= rtcv_pkg::RST_PIN1REG;
      pin2_r <= 24'h0;
      {corr_r, free1_r, free2_r, free3_r} <= 32'h0;
      ext1_r <= 27'h0;
      ext2_r <= 27'h0;
    end
    else if (init_pulse)
    begin
      st1_r <= pwdata[7:0] & rtcv_pkg::S1_INIT_KEEP;
      st2_r <= 8'h00;
      pin1_r <= 24'h0;
      pin2_r <= 24'h0;
      {corr_r, free1_r, free2_r, free3_r} <= 32'h0;
      ext1_r <= 27'h0;
      ext2_r <= 27'h0;
    end
    else
    begin
      if (lv_set)
        st1_r[rtcv_pkg::S1_LOW_VOLT] <= 1'b1;
      else if (lv_clr)
        st1_r[rtcv_pkg::S1_LOW_VOLT] <= 1'b0;
      if (apb_wr)
      begin
        case (paddr)
          rtcv_pkg::OFF_STATUS1: st1_r[7:2] <= pwdata[7:2];
          rtcv_pkg::OFF_STATUS2: st2_r <= pwdata[7:0];
          rtcv_pkg::OFF_PIN1REG: pin1_r <= pwdata[23:0];
          rtcv_pkg::OFF_PIN2REG: pin2_r <= pwdata[23:0];
          rtcv_pkg::OFF_CORR: corr_r <= pwdata[7:0];
          rtcv_pkg::OFF_FREE1: free1_r <= pwdata[7:0];
          rtcv_pkg::OFF_FREE2: free2_r <= pwdata[7:0];
          rtcv_pkg::OFF_FREE3: free3_r <= pwdata[7:0];
          rtcv_pkg::OFF_ALEXT1: ext1_r <= pwdata[26:0];
          rtcv_pkg::OFF_ALEXT2: ext2_r <= pwdata[26:0];
          default: ;
        endcase
      end
    end
  end

  // date write: fix the written field, then the end-of-month check
  always_comb
  begin
    cy = year_r;
    cm = mon_r;
    cd = day_r;
    fx = pwdata[7:0];
    if (paddr == rtcv_pkg::OFF_YEAR)
      cy = nib_ok(fx) ? fx : 8'h00;
    if (paddr == rtcv_pkg::OFF_MONTH)
      cm = (nib_ok(fx) && fx >= 8'h01 && fx <= 8'h12) ? fx : 8'h01;
    if (paddr == rtcv_pkg::OFF_DAY)
      cd = (nib_ok(fx) && fx >= 8'h01 && fx <= 8'h31) ? fx : 8'h01;
    nd = cd;
    nm = cm;
    ny = cy;
    if (cd > dim(cm, cy))
    begin
      nd = 8'h01;
      nm = (cm == 8'h12) ? 8'h01 : bcd_inc(cm);
      ny = (cm != 8'h12) ? cy : (cy == 8'h99) ? 8'h00 : bcd_inc(cy);
    end
  end

  // calendar counters
  always_ff @(posedge clk)
  begin
    min_step_r <= 1'b0;
    if (!nrst || init_pulse)
    begin
      year_r <= 8'h00;
      mon_r <= rtcv_pkg::RST_DATE;
      day_r <= rtcv_pkg::RST_DATE;
      wday_r <= 3'h0;
      hour_r <= 8'h00;
      min_r <= 8'h00;
      sec_r <= 8'h00;
      min_step_r <= 1'b0;
    end
    else if (apb_wr)
    begin
      case (paddr)
        rtcv_pkg::OFF_YEAR, rtcv_pkg::OFF_MONTH, rtcv_pkg::OFF_DAY:
        begin
          year_r <= ny;
          mon_r <= nm;
          day_r <= nd;
        end
        rtcv_pkg::OFF_WDAY:
          wday_r <= (pwdata[2:0] == 3'h7) ? 3'h0 : pwdata[2:0];
        rtcv_pkg::OFF_HOUR:
          if (h24)
            hour_r <= (nib_ok({2'b00, pwdata[5:0]}) && pwdata[5:0] <= 6'h23)
              ? {2'b00, pwdata[5:0]} : 8'h00;
          else if (nib_ok({2'b00, pwdata[5:0]}) && pwdata[5:0] <= 6'h11)
            hour_r <= {1'b0, pwdata[rtcv_pkg::HOUR_PM], pwdata[5:0]};
          else
            hour_r <= {1'b0, pwdata[rtcv_pkg::HOUR_PM], 6'h00};
        rtcv_pkg::OFF_MIN:
          min_r <= (nib_ok(pwdata[7:0]) && pwdata[7:0] <= 8'h59)
            ? pwdata[7:0] : 8'h00;
        rtcv_pkg::OFF_SEC:
          sec_r <= pwdata[7:0];
        default: ;
      endcase
    end
    else if (sec_tick)
    begin
      if (!nib_ok(sec_r) || sec_r >= 8'h59)
      begin
        sec_r <= 8'h00;
        min_step_r <= 1'b1;
        if (min_r == 8'h59)
        begin
          min_r <= 8'h00;
          if (hour_r[5:0] == (h24 ? 6'h23 : 6'h11))
          begin
            hour_r <= {1'b0, !h24 && !hour_r[rtcv_pkg::HOUR_PM], 6'h00};
            if (h24 || hour_r[rtcv_pkg::HOUR_PM])
            begin
              wday_r <= (wday_r == 3'h6) ? 3'h0 : wday_r + 3'h1;
              if (day_r >= dim(mon_r, year_r))
              begin
                day_r <= 8'h01;
                mon_r <= (mon_r == 8'h12) ? 8'h01 : bcd_inc(mon_r);
                if (mon_r == 8'h12)
                  year_r <= (year_r == 8'h99) ? 8'h00 : bcd_inc(year_r);
              end
              else
                day_r <= bcd_inc(day_r);
            end
          end
          else
            hour_r[5:0] <= 6'(bcd_inc({2'b00, hour_r[5:0]}));
        end
        else
          min_r <= bcd_inc(min_r);
      end
      else
        sec_r <= bcd_inc(sec_r);
    end
  end

  // alarm latches per pin
  assign hit1 = hit(pin1_r, ext1_r, wday_r, hour_r, pm_rd, h24, min_r, year_r,
    mon_r, day_r);
  assign hit2 = hit(pin2_r, ext2_r, wday_r, hour_r, pm_rd, h24, min_r, year_r,
    mon_r, day_r);
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      hit1_r <= 1'b0;
      hit2_r <= 1'b0;
      al1_r <= 1'b0;
      al2_r <= 1'b0;
    end
    else
    begin
      hit1_r <= hit1;
      hit2_r <= hit2;
      // new match or a minute step inside the match asserts
      if (!st2_r[rtcv_pkg::S2_P1_ALARM])
        al1_r <= 1'b0;
      else if (hit1 && (!hit1_r || min_step_r))
        al1_r <= 1'b1;
      if (!st2_r[rtcv_pkg::S2_P2_ALARM])
        al2_r <= 1'b0;
      else if (hit2 && (!hit2_r || min_step_r))
        al2_r <= 1'b1;
    end
  end

  // pin levels: frequency bits 7..3 line up with the 1..16 Hz divider taps
  assign lvl1 = st2_r[rtcv_pkg::S2_P1_32K] ? osc_s2_r :
    st2_r[rtcv_pkg::S2_P1_FREQ] ? &(~pin1_r[7:3] | sub_r) :
    !al1_r;
  assign lvl2 = st2_r[rtcv_pkg::S2_P2_FREQ] ? &(~pin2_r[7:3] | sub_r) :
    !al2_r;
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      interrupt_pin_one_oe <= 1'b0;
      interrupt_pin_two_oe <= 1'b0;
    end
    else
    begin
      interrupt_pin_one_oe <= !lvl1;
      interrupt_pin_two_oe <= !lvl2;
    end
  end
  assign interrupt_pin_one_o = 1'b0;
  assign interrupt_pin_two_o = 1'b0;

  a_poc_after_reset: assert property (@(posedge clk) disable iff (!nrst)
    $past(!nrst) |-> st1_r[rtcv_pkg::S1_POWER_ON] && st2_r == 8'h01)
    else $error("power-on flag or mode missing after reset");
  a_init_clears: assert property (@(posedge clk) disable iff (!nrst)
    init_pulse |=> st1_r[3:0] == 4'h0 && st1_r[7] == 1'b0 && st2_r == 8'h00)
    else $error("init left status bits set");
  a_upcnt_kept: assert property (@(posedge clk) disable iff (!nrst)
    init_pulse && !sec_tick |=> $stable(upcnt_r))
    else $error("init disturbed the elapsed counter");
  a_lv_holds: assert property (@(posedge clk) disable iff (!nrst)
    st1_r[rtcv_pkg::S1_LOW_VOLT] && !lv_clr |=> st1_r[rtcv_pkg::S1_LOW_VOLT]
      && !lv_samp_r)
    else $error("low-voltage flag dropped or sampling kept on");
  a_lv_read_clr: assert property (@(posedge clk) disable iff (!nrst)
    lv_clr && !lv_set |=> !st1_r[rtcv_pkg::S1_LOW_VOLT])
    else $error("flag read did not clear low-voltage flag");
  a_month_fix: assert property (@(posedge clk) disable iff (!nrst)
    apb_wr && paddr == rtcv_pkg::OFF_MONTH && pwdata[7:0] == 8'h13
      |=> mon_r == 8'h01)
    else $error("invalid month not replaced");
  a_min_fix: assert property (@(posedge clk) disable iff (!nrst)
    apb_wr && paddr == rtcv_pkg::OFF_MIN &&
      (pwdata[7:0] > 8'h59 || pwdata[3:0] > 4'h9)
      |=> min_r == 8'h00)
    else $error("invalid minute not forced to zero");
  a_alarm_hold: assert property (@(posedge clk) disable iff (!nrst)
    al1_r && st2_r[rtcv_pkg::S2_P1_ALARM] |=> al1_r)
    else $error("alarm released while enabled");
  a_freq_pin: assert property (@(posedge clk) disable iff (!nrst)
    st2_r[rtcv_pkg::S2_P1_FREQ] && !st2_r[rtcv_pkg::S2_P1_32K]
      |=> interrupt_pin_one_oe == !$past(&(~pin1_r[7:3] | sub_r)))
    else $error("pin one does not follow the frequency product");
endmodule
`default_nettype wire

/* rtcv_far_model.sv */
// oscillator, supply monitor and board pull-ups around the clock block
`timescale 1ns/10ps
`default_nettype none
module rtcv_far_model (
  // oscillator and supply monitor
  output logic osc_clk,
  output logic vdd_low,
  // supply drop request from the bench
  input wire logic supply_drop,
  // interrupt pin drivers from the block
  input wire logic pin_one_o,
  input wire logic pin_one_oe,
  input wire logic pin_two_o,
  input wire logic pin_two_oe,
  // resolved board levels
  output logic pin_one,
  output logic pin_two
);
  // crystal starts off the bus clock grid so the two never line up
  initial
  begin
    osc_clk = 1'h0;
    #137;
    forever #200 osc_clk = ~osc_clk;
  end
  // supply monitor output follows the bench's drop request
  assign vdd_low = supply_drop;
  // released pins are pulled high on the board
  assign pin_one = pin_one_oe ? pin_one_o : 1'h1;
  assign pin_two = pin_two_oe ? pin_two_o : 1'h1;
endmodule
`default_nettype wire

/* testbench.sv */
// self-checking bench for the calendar status and validation block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk = 1'h0;
  logic nrst = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic supply_drop = 1'h0;
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  wire osc_clk;
  wire vdd_low;
  wire p1_o;
  wire p1_oe;
  wire p2_o;
  wire p2_oe;
  wire pin_one;
  wire pin_two;
  int err_total = 0;
  int check_count = 0;
  logic [31:0] rdat;
  logic last_err;
  int lo;

  always #25 clk = ~clk;

  // a short divider makes one second 1024 clocks
  rtcv_core #(.LV_SAMPLE_CYCLES(20), .OSC_TICK_EDGES(4)) i_rtcv_core (
    .clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .osc_clk(osc_clk),
    .vdd_low(vdd_low), .interrupt_pin_one_o(p1_o),
    .interrupt_pin_one_oe(p1_oe), .interrupt_pin_two_o(p2_o),
    .interrupt_pin_two_oe(p2_oe));

  rtcv_far_model i_rtcv_far_model (
    .osc_clk(osc_clk), .vdd_low(vdd_low), .supply_drop(supply_drop),
    .pin_one_o(p1_o), .pin_one_oe(p1_oe), .pin_two_o(p2_o),
    .pin_two_oe(p2_oe),
    .pin_one(pin_one), .pin_two(pin_two));

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  // one transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rdat = prdata;
    last_err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic rc(input string nm, input logic [7:0] a, logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(nm, rdat, e);
  endtask

  task automatic wc(input string nm, input logic [7:0] a, logic [31:0] d, e);
    apb(1'h1, a, d);
    rc(nm, a, e);
  endtask

  task automatic watch(input bit p2, input int n);
    lo = 0;
    repeat (n)
    begin
      @(posedge clk);
      lo += ((p2 ? pin_two : pin_one) === 1'h0);
    end
  endtask

  task t_reset;
    watch(1'h0, 1100);
    chk("p1hz", lo > 400 && lo < 700, 1);
    rc("st1", rtcv_pkg::OFF_STATUS1, 32'h1);
    rc("st2", rtcv_pkg::OFF_STATUS2, 32'h1);
    rc("pin1", rtcv_pkg::OFF_PIN1REG, 32'h80);
    rc("pin2", rtcv_pkg::OFF_PIN2REG, 32'h0);
    rc("mon", rtcv_pkg::OFF_MONTH, 32'h1);
    rc("day", rtcv_pkg::OFF_DAY, 32'h1);
    rc("upc", rtcv_pkg::OFF_UPCNT, 32'h0);
    chk("p2lvl", pin_two, 1'h1);
    apb(1'h1, rtcv_pkg::OFF_CORR, 32'h5A);
    apb(1'h1, rtcv_pkg::OFF_FREE2, 32'hC3);
    apb(1'h1, rtcv_pkg::OFF_ALEXT1, 32'h0712_3104);
    apb(1'h1, rtcv_pkg::OFF_PIN2REG, 32'hF8);
    apb(1'h1, rtcv_pkg::OFF_UPCNT, 32'h123);
    apb(1'h1, rtcv_pkg::OFF_INIT, 32'hFF);
    rc("st1i", rtcv_pkg::OFF_STATUS1, 32'h70);
    rc("st2i", rtcv_pkg::OFF_STATUS2, 32'h0);
    rc("pin1i", rtcv_pkg::OFF_PIN1REG, 32'h0);
    rc("pin2i", rtcv_pkg::OFF_PIN2REG, 32'h0);
    rc("corr", rtcv_pkg::OFF_CORR, 32'h0);
    rc("free2", rtcv_pkg::OFF_FREE2, 32'h0);
    rc("alx1", rtcv_pkg::OFF_ALEXT1, 32'h0);
    rc("upci", rtcv_pkg::OFF_UPCNT, 32'h0);
    apb(1'h0, 8'h4C, 32'h0);
    chk("unmap", last_err, 1'h1);
    $display("reset and init done");
  endtask

  task t_date;
    wc("yr", rtcv_pkg::OFF_YEAR, 32'hA5, 32'h0);
    wc("yr", rtcv_pkg::OFF_YEAR, 32'h4A, 32'h0);
    wc("yr", rtcv_pkg::OFF_YEAR, 32'h99, 32'h99);
    wc("mon", rtcv_pkg::OFF_MONTH, 32'h0, 32'h1);
    wc("mon", rtcv_pkg::OFF_MONTH, 32'h13, 32'h1);
    wc("mon", rtcv_pkg::OFF_MONTH, 32'h1A, 32'h1);
    wc("mon", rtcv_pkg::OFF_MONTH, 32'h12, 32'h12);
    wc("day", rtcv_pkg::OFF_DAY, 32'h0, 32'h1);
    wc("day", rtcv_pkg::OFF_DAY, 32'h32, 32'h1);
    wc("day", rtcv_pkg::OFF_DAY, 32'h0F, 32'h1);
    wc("day", rtcv_pkg::OFF_DAY, 32'h31, 32'h31);
    wc("wd", rtcv_pkg::OFF_WDAY, 32'h7, 32'h0);
    wc("wd", rtcv_pkg::OFF_WDAY, 32'h6, 32'h6);
    wc("eom", rtcv_pkg::OFF_MONTH, 32'h2, 32'h3);
    rc("eomd", rtcv_pkg::OFF_DAY, 32'h1);
    wc("mon", rtcv_pkg::OFF_MONTH, 32'h4, 32'h4);
    wc("eomd", rtcv_pkg::OFF_DAY, 32'h31, 32'h1);
    rc("eom", rtcv_pkg::OFF_MONTH, 32'h5);
    $display("date checks done");
  endtask

  task t_time;
    wc("hr", rtcv_pkg::OFF_HOUR, 32'h15, 32'h55);
    wc("hr", rtcv_pkg::OFF_HOUR, 32'h49, 32'h09);
    wc("hr", rtcv_pkg::OFF_HOUR, 32'h24, 32'h0);
    wc("hr", rtcv_pkg::OFF_HOUR, 32'h3A, 32'h0);
    wc("min", rtcv_pkg::OFF_MIN, 32'h60, 32'h0);
    wc("min", rtcv_pkg::OFF_MIN, 32'h5A, 32'h0);
    wc("min", rtcv_pkg::OFF_MIN, 32'h59, 32'h59);
    apb(1'h1, rtcv_pkg::OFF_INIT, 32'h0);
    rc("st1", rtcv_pkg::OFF_STATUS1, 32'h0);
    wc("h12", rtcv_pkg::OFF_HOUR, 32'h12, 32'h0);
    wc("h12", rtcv_pkg::OFF_HOUR, 32'h20, 32'h0);
    wc("h12", rtcv_pkg::OFF_HOUR, 32'h51, 32'h51);
    $display("time checks done");
  endtask

  task t_pins;
    apb(1'h1, rtcv_pkg::OFF_INIT, 32'h40);
    watch(1'h0, 100);
    chk("p1off", lo, 0);
    apb(1'h1, rtcv_pkg::OFF_STATUS2, 32'h04);
    watch(1'h0, 40);
    chk("p1clk", (lo > 0 && lo < 40), 1);
    apb(1'h1, rtcv_pkg::OFF_STATUS2, 32'h0);
    wc("p1st", rtcv_pkg::OFF_PIN1REG, 32'hFF, 32'hFF);
    apb(1'h1, rtcv_pkg::OFF_PIN2REG, 32'h0);
    apb(1'h1, rtcv_pkg::OFF_PIN2REG, 32'h81_8080);
    apb(1'h1, rtcv_pkg::OFF_STATUS2, 32'h10);
    apb(1'h1, rtcv_pkg::OFF_PIN2REG, 32'h80_8080);
    watch(1'h1, 5);
    chk("p2al", lo > 0, 1);
    apb(1'h1, rtcv_pkg::OFF_STATUS2, 32'h0);
    watch(1'h1, 3);
    chk("p2rel", pin_two, 1'h1);
    apb(1'h1, rtcv_pkg::OFF_STATUS2, 32'h10);
    watch(1'h1, 50);
    chk("p2re", lo, 0);
    $display("pin checks done");
  endtask

  task t_supply;
    supply_drop <= 1'h1;
    repeat (1200) @(posedge clk);
    supply_drop <= 1'h0;
    repeat (1200) @(posedge clk);
    rc("lvset", rtcv_pkg::OFF_STATUS1, 32'h42);
    rc("lvclr", rtcv_pkg::OFF_STATUS1, 32'h40);
    apb(1'h1, rtcv_pkg::OFF_SEC, 32'h75);
    do apb(1'h0, rtcv_pkg::OFF_SEC, 32'h0); while (rdat[7:0] == 8'h75);
    chk("secfix", rdat, 32'h0);
    rc("secmin", rtcv_pkg::OFF_MIN, 32'h1);
    $display("supply and carry checks done");
  endtask

  task stop_test;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // the whole sequence needs a few thousand cycles
  initial
  begin
    #(50 * 40000);
    err_total++;
    stop_test;
  end

  initial
  begin
    repeat (12) @(posedge clk);
    nrst <= 1'h1;
    t_reset;
    t_date;
    t_time;
    t_pins;
    t_supply;
    stop_test;
  end
endmodule
`default_nettype wire
